/* include/vfd_pkg.sv */
// package: shared constants and types of the vliw fetch and dispatch core
package vfd_pkg;
	// ****************************************
	// widths and counts
	// ****************************************
	localparam int FP_WORDS  = 8;
	localparam int FP_W      = 256;
	localparam int NUM_UNITS = 8;
	localparam int NUM_REGS  = 16;
	localparam int WR_PORTS  = 10;
	localparam int CIRC_LOG2 = 8;

	// ****************************************
	// reset values and fetch step
	// ****************************************
	localparam logic [31:0] RESET_PC  = 32'h0000_0000;
	localparam logic [31:0] FP_BYTES  = 32'h0000_0020;
	localparam logic [2:0]  RESET_POS = 3'h0;

	// ****************************************
	// instruction field positions
	// ****************************************
	localparam int P_BIT     = 0;
	localparam int UNIT_LSB  = 1;
	localparam int DSIZE_LSB = 5;
	localparam int D_LONG    = 4;
	localparam int D_STORE   = 7;
	localparam int OP_LSB    = 8;
	localparam int CROSS_BIT = 12;
	localparam int CIRC_BIT  = 12;
	localparam int SRC1_LSB  = 13;
	localparam int SRC2_LSB  = 18;
	localparam int DST_LSB   = 23;
	localparam int Z_BIT     = 28;
	localparam int CREG_LSB  = 29;

	// ****************************************
	// unit slots, opcodes, sizes
	// ****************************************
	localparam logic [1:0] U_LOGIC = 2'h0;
	localparam logic [1:0] U_SHIFT = 2'h1;
	localparam logic [1:0] U_MUL   = 2'h2;
	localparam logic [1:0] U_DADDR = 2'h3;
	localparam logic [3:0] OP_ADD  = 4'h0;
	localparam logic [3:0] OP_SUB  = 4'h1;
	localparam logic [3:0] OP_AND  = 4'h2;
	localparam logic [3:0] OP_OR   = 4'h3;
	localparam logic [3:0] OP_XOR  = 4'h4;
	localparam logic [3:0] OP_SHL  = 4'h0;
	localparam logic [3:0] OP_SHR  = 4'h1;
	localparam logic [3:0] OP_SRA  = 4'h2;
	localparam logic [3:0] OP_MPY  = 4'h0;
	localparam logic [3:0] OP_MAC  = 4'h1;
	localparam logic [3:0] OP_MPYU = 4'h2;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [3:0] LONG_BASE = 4'he;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {VFD_REQ, VFD_WAIT, VFD_RUN} vfd_state_t;
	typedef struct packed {logic valid; logic [FP_W-1:0] data;} vfd_fetch_rsp_t;
	typedef struct packed {
		logic req; logic we; logic [31:0] addr; logic [3:0] be; logic [31:0] wdata;
	} vfd_mem_req_t;
	typedef struct packed {logic en; logic [3:0] idx; logic [31:0] data;} vfd_wr_t;
	typedef struct packed {
		logic valid; logic side; logic [3:0] idx; logic [1:0] size; logic [1:0] lane;
	} vfd_load_t;
	typedef struct packed {logic [NUM_REGS-1:0][31:0] r;} vfd_rf_t;
	typedef struct packed {
		vfd_state_t                     fsm;
		logic [31:0]                    pc;
		logic [FP_W-1:0]                pkt;
		logic [2:0]                     pos;
		logic [NUM_UNITS-1:0]           iv;
		logic [NUM_UNITS-1:0][31:0]     iw;
		vfd_mem_req_t [1:0]             mem;
		vfd_load_t [1:0]                ld;
		vfd_load_t [1:0]                ldw;
		logic                           xconf;
		logic                           uconf;
	} vfd_core_st_t;
endpackage : vfd_pkg

/* hdl/vfd_regfile.sv */
// module: one side's sixteen-entry general register file
`timescale 1ns/1ps
`default_nettype none
module vfd_regfile #(
	parameter int NW = vfd_pkg::WR_PORTS
) (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	// write ports, higher index wins
	input  wire vfd_pkg::vfd_wr_t [NW-1:0] wr,
	// whole file, all units read in one cycle
	output vfd_pkg::vfd_rf_t               regs
);
	vfd_pkg::vfd_rf_t st_r;
	vfd_pkg::vfd_rf_t st_nxt;

	// apply enabled writes in port order
	always_comb begin
		st_nxt = st_r;
		for (int k = 0; k < NW; k++) begin
			if (wr[k].en) begin
				st_nxt.r[wr[k].idx] = wr[k].data;
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign regs = st_r;
endmodule : vfd_regfile
`default_nettype wire

/* hdl/vfd_daddr.sv */
// module: data-address unit address generator, linear or circular
`timescale 1ns/1ps
`default_nettype none
module vfd_daddr (
	// instruction word and base register value
	input  wire logic [31:0] word,
	input  wire logic [31:0] base,
	// effective byte address
	output logic [31:0]      addr
);
	logic        lng;
	logic [31:0] off;
	logic [31:0] lin;

	// offset extend, scale by access size, wrap if circular
	always_comb begin
		lng = word[vfd_pkg::D_LONG];
		if (lng) begin
			off = {{17{word[22]}}, word[22:8]};
		end else begin
			off = {{27{word[17]}}, word[17:13]};
		end
		if (word[vfd_pkg::DSIZE_LSB +: 2] == vfd_pkg::SZ_HALF) begin
			off = {off[30:0], 1'h0};
		end else if (word[vfd_pkg::DSIZE_LSB +: 2] != vfd_pkg::SZ_BYTE) begin
			off = {off[29:0], 2'h0};
		end
		lin = base + off;
		if (!lng && word[vfd_pkg::CIRC_BIT]) begin
			addr = {base[31:vfd_pkg::CIRC_LOG2], lin[vfd_pkg::CIRC_LOG2-1:0]};
		end else begin
			addr = lin;
		end
	end
endmodule : vfd_daddr
`default_nettype wire

/* hdl/vfd_core.sv */
// module: vliw fetch, execute-packet split, dispatch and execute core
`timescale 1ns/1ps
`default_nettype none

module vfd_core (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	// program fetch port
	output logic                               fetch_req,
	output logic [31:0]                        fetch_addr,
	input  wire vfd_pkg::vfd_fetch_rsp_t       fetch_rsp,
	// data memory ports, one per data-address unit
	output vfd_pkg::vfd_mem_req_t [1:0]        dmem_req,
	input  wire logic [1:0][31:0]              dmem_rdata,
	// dispatched execute packet
	output logic                               ep_valid,
	output logic [vfd_pkg::NUM_UNITS-1:0]      unit_valid,
	output logic [vfd_pkg::NUM_UNITS-1:0][31:0] unit_word,
	// refused work
	output logic                               cross_conflict,
	output logic                               unit_conflict
);
	// ****************************************
	// declarations
	// ****************************************
	vfd_pkg::vfd_core_st_t                     st_r;
	vfd_pkg::vfd_core_st_t                     st_nxt;
	vfd_pkg::vfd_rf_t [1:0]                    rf;
	vfd_pkg::vfd_wr_t [1:0][vfd_pkg::WR_PORTS-1:0] wr;
	logic [1:0][31:0]                          dbase;
	logic [1:0][31:0]                          dad;

	// ****************************************
	// helper functions
	// ****************************************
	// word i of a fetch packet, word 0 at the lowest address
	function automatic logic [31:0] fpw(input logic [255:0] p, input logic [2:0] i);
		return p[{i, 5'h0} +: 32];
	endfunction : fpw

	// index of the word that closes the execute packet starting at s
	function automatic logic [2:0] ep_end(input logic [255:0] p, input logic [2:0] s);
		logic [2:0] e;
		e = 3'h7;
		for (int i = vfd_pkg::FP_WORDS - 1; i >= 0; i--) begin
			if (i >= s && (!p[32*i + vfd_pkg::P_BIT] || i == vfd_pkg::FP_WORDS - 1)) begin
				e = 3'(i);
			end
		end
		return e;
	endfunction : ep_end

	// condition register test, code zero always true, spare codes never
	function automatic logic cond_ok(input logic [31:0] w, input vfd_pkg::vfd_rf_t [1:0] f);
		logic [31:0] v;
		logic        known;
		v = 32'h0;
		known = 1'h1;
		case (w[vfd_pkg::CREG_LSB +: 3])
			3'h0: return 1'h1;
			3'h1: v = f[0].r[1];
			3'h2: v = f[0].r[2];
			3'h3: v = f[1].r[0];
			3'h4: v = f[1].r[1];
			3'h5: v = f[1].r[2];
			default: known = 1'h0;
		endcase
		return known && (w[vfd_pkg::Z_BIT] ? (v == 32'h0) : (v != 32'h0));
	endfunction : cond_ok

	// 16 by 16 multiply, signed or unsigned, 32-bit product
	function automatic logic [31:0] mul16(input logic [31:0] a, input logic [31:0] b,
			input logic [3:0] op);
		if (op == vfd_pkg::OP_MPYU) begin
			return {16'h0, a[15:0]} * {16'h0, b[15:0]};
		end
		return {{16{a[15]}}, a[15:0]} * {{16{b[15]}}, b[15:0]};
	endfunction : mul16

	// byte enables for a store of the given size at the given lane
	function automatic logic [3:0] be_of(input logic [1:0] sz, input logic [1:0] ln);
		case (sz)
			vfd_pkg::SZ_BYTE: return 4'(4'h1 << ln);
			vfd_pkg::SZ_HALF: return ln[1] ? 4'hc : 4'h3;
			default: return 4'hf;
		endcase
	endfunction : be_of

	// pick loaded bytes from the lane and sign extend
	function automatic logic [31:0] ld_fmt(input logic [31:0] d, input logic [1:0] sz,
			input logic [1:0] ln);
		logic [31:0] s;
		s = d >> {ln, 3'h0};
		case (sz)
			vfd_pkg::SZ_BYTE: return {{24{s[7]}}, s[7:0]};
			vfd_pkg::SZ_HALF: return {{16{s[15]}}, s[15:0]};
			default: return d;
		endcase
	endfunction : ld_fmt

	// ****************************************
	// register files and address generators
	// ****************************************
	for (genvar s = 0; s < 2; s++) begin : g_side
		// one register file per side
		vfd_regfile #(
			.NW(vfd_pkg::WR_PORTS)
		) u_rf (
			.clk    (clk),
			.reset_n(reset_n),
			.wr     (wr[s]),
			.regs   (rf[s])
		);

		// long form uses the fixed base register
		assign dbase[s] = st_r.iw[4*s+3][vfd_pkg::D_LONG] ?
			rf[s].r[vfd_pkg::LONG_BASE] :
			rf[s].r[st_r.iw[4*s+3][vfd_pkg::SRC2_LSB +: 4]];

		// address from this side's file only
		vfd_daddr u_daddr (
			.word(st_r.iw[4*s+3]),
			.base(dbase[s]),
			.addr(dad[s])
		);
	end

	// ****************************************
	// fetch, split, dispatch and execute
	// ****************************************
	always_comb begin
		logic        sd;
		logic        dsd;
		logic        xs;
		logic        xd;
		logic        go;
		logic [2:0]  ui;
		logic [31:0] w;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] res;
		logic [3:0]  op;
		logic [3:0]  dst;
		logic [1:0]  sz;
		logic [1:0]  xr;
		logic [1:0]  xw;
		logic [2:0]  e;
		logic [2:0]  tu;
		logic [7:0]  tk;
		sd = 1'h0;
		dsd = 1'h0;
		xs = 1'h0;
		xd = 1'h0;
		go = 1'h0;
		ui = 3'h0;
		w = 32'h0;
		a = 32'h0;
		b = 32'h0;
		res = 32'h0;
		op = 4'h0;
		dst = 4'h0;
		sz = 2'h0;
		xr = 2'h0;
		xw = 2'h0;
		e = 3'h0;
		tu = 3'h0;
		tk = 8'h0;
		st_nxt = st_r;
		st_nxt.iv = '0;
		st_nxt.mem = '0;
		st_nxt.ld = '0;
		st_nxt.xconf = 1'h0;
		st_nxt.uconf = 1'h0;
		wr = '0;

		// load data returns, written before unit results
		st_nxt.ldw = st_r.ld;
		for (int d = 0; d < 2; d++) begin
			if (st_r.ldw[d].valid) begin
				wr[st_r.ldw[d].side][d].en = 1'h1;
				wr[st_r.ldw[d].side][d].idx = st_r.ldw[d].idx;
				wr[st_r.ldw[d].side][d].data =
					ld_fmt(dmem_rdata[d], st_r.ldw[d].size, st_r.ldw[d].lane);
			end
		end

		// execute the issued packet, all units in parallel
		for (int u = 0; u < vfd_pkg::NUM_UNITS; u++) begin
			ui = 3'(u);
			sd = ui[2];
			w = st_r.iw[u];
			op = w[vfd_pkg::OP_LSB +: 4];
			dst = w[vfd_pkg::DST_LSB +: 4];
			dsd = w[vfd_pkg::DST_LSB + 4];
			go = st_r.iv[u] && cond_ok(w, rf);
			xs = w[vfd_pkg::CROSS_BIT] && ui[1:0] != vfd_pkg::U_DADDR;
			xd = dsd != sd && ui[1:0] != vfd_pkg::U_DADDR;
			a = rf[sd].r[w[vfd_pkg::SRC1_LSB +: 4]];
			b = rf[sd ^ xs].r[w[vfd_pkg::SRC2_LSB +: 4]];
			// one cross read per side, later units refused
			if (go && xs) begin
				if (xr[sd]) begin
					go = 1'h0;
					st_nxt.xconf = 1'h1;
				end else begin
					xr[sd] = 1'h1;
				end
			end
			// one cross write per side, later units refused
			if (go && xd) begin
				if (xw[sd]) begin
					go = 1'h0;
					st_nxt.xconf = 1'h1;
				end else begin
					xw[sd] = 1'h1;
				end
			end
			res = 32'h0;
			case (ui[1:0])
				vfd_pkg::U_LOGIC: begin
					case (op)
						vfd_pkg::OP_ADD: res = a + b;
						vfd_pkg::OP_SUB: res = a - b;
						vfd_pkg::OP_AND: res = a & b;
						vfd_pkg::OP_OR:  res = a | b;
						vfd_pkg::OP_XOR: res = a ^ b;
						default: res = 32'(a == b);
					endcase
				end
				vfd_pkg::U_SHIFT: begin
					case (op)
						vfd_pkg::OP_SHL: res = b << a[4:0];
						vfd_pkg::OP_SHR: res = b >> a[4:0];
						vfd_pkg::OP_SRA: res = $signed(b) >>> a[4:0];
						default: res = {{17{w[22]}}, w[22:8]};
					endcase
				end
				vfd_pkg::U_MUL: begin
					res = mul16(a, b, op);
					if (op == vfd_pkg::OP_MAC) begin
						res = rf[dsd].r[dst] + res;
					end
				end
				default: begin
					// data-address unit: memory access, data on either side
					sz = w[vfd_pkg::DSIZE_LSB +: 2];
					if (sz != vfd_pkg::SZ_BYTE && sz != vfd_pkg::SZ_HALF) begin
						sz = 2'h2;
					end
					if (go) begin
						st_nxt.mem[sd].req = 1'h1;
						st_nxt.mem[sd].we = w[vfd_pkg::D_STORE];
						st_nxt.mem[sd].addr = dad[sd];
						st_nxt.mem[sd].be = be_of(sz, dad[sd][1:0]);
						case (sz)
							vfd_pkg::SZ_BYTE: st_nxt.mem[sd].wdata = {4{rf[dsd].r[dst][7:0]}};
							vfd_pkg::SZ_HALF: st_nxt.mem[sd].wdata = {2{rf[dsd].r[dst][15:0]}};
							default: st_nxt.mem[sd].wdata = rf[dsd].r[dst];
						endcase
						if (!w[vfd_pkg::D_STORE]) begin
							st_nxt.ld[sd].valid = 1'h1;
							st_nxt.ld[sd].side = dsd;
							st_nxt.ld[sd].idx = dst;
							st_nxt.ld[sd].size = sz;
							st_nxt.ld[sd].lane = dad[sd][1:0];
						end
					end
					go = 1'h0;
				end
			endcase
			// result write on the destination side
			wr[dsd][2+u].en = go;
			wr[dsd][2+u].idx = dst;
			wr[dsd][2+u].data = res;
		end

		// fetch sequencer and execute-packet split
		case (st_r.fsm)
			vfd_pkg::VFD_REQ: begin
				st_nxt.fsm = vfd_pkg::VFD_WAIT;
			end
			vfd_pkg::VFD_WAIT: begin
				if (fetch_rsp.valid) begin
					st_nxt.pkt = fetch_rsp.data;
					st_nxt.pos = vfd_pkg::RESET_POS;
					st_nxt.fsm = vfd_pkg::VFD_RUN;
				end
			end
			vfd_pkg::VFD_RUN: begin
				e = ep_end(st_r.pkt, st_r.pos);
				for (int i = 0; i < vfd_pkg::FP_WORDS; i++) begin
					if (3'(i) >= st_r.pos && 3'(i) <= e) begin
						w = fpw(st_r.pkt, 3'(i));
						tu = w[vfd_pkg::UNIT_LSB +: 3];
						if (tk[tu]) begin
							st_nxt.uconf = 1'h1;
						end else begin
							tk[tu] = 1'h1;
							st_nxt.iv[tu] = 1'h1;
							st_nxt.iw[tu] = w;
						end
					end
				end
				st_nxt.pos = 3'(e + 3'h1);
				if (e == 3'h7) begin
					st_nxt.fsm = vfd_pkg::VFD_REQ;
					st_nxt.pc = st_r.pc + vfd_pkg::FP_BYTES;
				end
			end
			default: begin
				st_nxt.fsm = vfd_pkg::VFD_REQ;
			end
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.fsm <= vfd_pkg::VFD_REQ;
			st_r.pc <= vfd_pkg::RESET_PC;
			st_r.pos <= vfd_pkg::RESET_POS;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign fetch_req      = st_r.fsm == vfd_pkg::VFD_REQ;
	assign fetch_addr     = st_r.pc;
	assign dmem_req       = st_r.mem;
	assign ep_valid       = |st_r.iv;
	assign unit_valid     = st_r.iv;
	assign unit_word      = st_r.iw;
	assign cross_conflict = st_r.xconf;
	assign unit_conflict  = st_r.uconf;
endmodule : vfd_core
`default_nettype wire

/* tb/vfd_core_assertions.sv */
// checker: port-level properties of the fetch and dispatch core
`timescale 1ns/1ps
`default_nettype none
module vfd_core_assertions (
	// clock and reset
	input wire logic                               clk,
	input wire logic                               reset_n,
	// fetch port
	input wire logic                               fetch_req,
	input wire logic [31:0]                        fetch_addr,
	input wire vfd_pkg::vfd_fetch_rsp_t            fetch_rsp,
	// data memory
	input wire vfd_pkg::vfd_mem_req_t [1:0]        dmem_req,
	input wire logic [1:0][31:0]                   dmem_rdata,
	// dispatch and refusals
	input wire logic                               ep_valid,
	input wire logic [vfd_pkg::NUM_UNITS-1:0]      unit_valid,
	input wire logic [vfd_pkg::NUM_UNITS-1:0][31:0] unit_word,
	input wire logic                               cross_conflict,
	input wire logic                               unit_conflict
);
	// ****************************************
	// helper state and properties
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [31:0] last_r;
	logic        seen_r;
	// remember the previous fetch address
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			last_r <= 32'h0;
			seen_r <= 1'b0;
		end else if (fetch_req) begin
			last_r <= fetch_addr;
			seen_r <= 1'b1;
		end
	end
	sequence s_fetch_gap;
		fetch_req ##1 !ep_valid;
	endsequence
	sequence s_issue_a;
		unit_valid[3] && unit_word[3][31:29] == 3'h0;
	endsequence
	sequence s_issue_b;
		unit_valid[7] && unit_word[7][31:29] == 3'h0;
	endsequence
	fetch_pulse_a: assert property (fetch_req |=> !fetch_req)
		else $error("fetch request longer than one cycle");
	fetch_step_a: assert property (fetch_req && seen_r |-> fetch_addr == last_r + 32'h20)
		else $error("fetch address did not step by one packet");
	ep_or_a: assert property (ep_valid == (|unit_valid))
		else $error("packet valid differs from unit valids");
	quiet_wait_a: assert property (fetch_req |-> s_fetch_gap)
		else $error("dispatch while a fetch is outstanding");
	rsp_dispatch_a: assert property (fetch_rsp.valid && !ep_valid |-> ##2 ep_valid)
		else $error("no execute packet after fetch answer");
	stream_a: assert property (ep_valid && !fetch_req |=> ep_valid)
		else $error("gap between execute packets");
	daddr_side_a_a: assert property (s_issue_a |=> dmem_req[0].req)
		else $error("side a data access not issued");
	daddr_side_b_a: assert property (s_issue_b |=> dmem_req[1].req)
		else $error("side b data access not issued");
	never_cond_a: assert property (unit_valid[3] && unit_word[3][31:29] == 3'h6
		|=> !dmem_req[0].req)
		else $error("data access issued under a false condition");
	req_cause_a: assert property (dmem_req[0].req |-> $past(unit_valid[3]))
		else $error("data access without a data-address instruction");
	conflict_ep_a: assert property (unit_conflict |-> ep_valid)
		else $error("unit conflict flagged outside a dispatch");
	cross_late_a: assert property (cross_conflict |-> $past(ep_valid))
		else $error("cross conflict without a packet in the cycle before");
endmodule : vfd_core_assertions
bind vfd_core vfd_core_assertions vfd_core_assertions_inst (.clk(clk), .reset_n(reset_n),
	.fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_rsp(fetch_rsp),
	.dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .ep_valid(ep_valid),
	.unit_valid(unit_valid), .unit_word(unit_word), .cross_conflict(cross_conflict),
	.unit_conflict(unit_conflict));
`default_nettype wire

/* tb/vfd_prog_mem.sv */
// partner: program memory answering whole fetch packets
`timescale 1ns/1ps
`default_nettype none
module vfd_prog_mem (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               reset_n,
	// fetch port of the core
	input  wire logic               fetch_req,
	input  wire logic [31:0]        fetch_addr,
	output vfd_pkg::vfd_fetch_rsp_t fetch_rsp,
	// answer delay, zero is prompt
	input  wire logic [3:0]         lat
);
	// ****************************************
	// packet store and answer timing
	// ****************************************
	logic [255:0] mem [0:7];
	logic [2:0]   slot_r;
	logic [3:0]   cnt_r;
	logic         busy_r;
	// one request at a time, stale data inverted each cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_r <= 1'b0;
			fetch_rsp <= '0;
		end else begin
			fetch_rsp.valid <= 1'b0;
			fetch_rsp.data <= ~fetch_rsp.data;
			if (fetch_req && !busy_r) begin
				slot_r <= fetch_addr[7:5];
				cnt_r <= 4'h1;
				busy_r <= (lat != 4'h0);
				if (lat == 4'h0) begin
					fetch_rsp.valid <= 1'b1;
					fetch_rsp.data <= mem[fetch_addr[7:5]];
				end
			end else if (busy_r) begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r >= lat) begin
					fetch_rsp.valid <= 1'b1;
					fetch_rsp.data <= mem[slot_r];
					busy_r <= 1'b0;
				end
			end
		end
	end
endmodule : vfd_prog_mem
`default_nettype wire

/* tb/tb.sv */
// testbench: fetch, split and dispatch of execute packets
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, s) begin \
	compares++; \
	if ((a) !== (e)) begin \
		fails++; \
		$display("BAD %s exp %h got %h", s, (e), (a)); \
	end \
end
module tb;
	// ****************************************
	// signals and instances
	// ****************************************
	logic                        clk;
	logic                        reset_n;
	logic                        fetch_req;
	logic [31:0]                 fetch_addr;
	vfd_pkg::vfd_fetch_rsp_t     fetch_rsp;
	vfd_pkg::vfd_mem_req_t [1:0] dmem_req;
	logic [1:0][31:0]            dmem_rdata;
	logic                        ep_valid;
	logic                        cross_conflict;
	logic                        unit_conflict;
	logic [7:0]                  unit_valid;
	logic [7:0][31:0]            unit_word;
	logic [3:0]                  lat;
	int                          fails;
	int                          compares;
	vfd_core vfd_core_inst (.clk(clk), .reset_n(reset_n), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_rsp(fetch_rsp), .dmem_req(dmem_req),
		.dmem_rdata(dmem_rdata), .ep_valid(ep_valid), .unit_valid(unit_valid),
		.unit_word(unit_word), .cross_conflict(cross_conflict),
		.unit_conflict(unit_conflict));
	vfd_prog_mem prog_inst (.clk(clk), .reset_n(reset_n), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_rsp(fetch_rsp), .lat(lat));
	// wait for a packet, then judge each execute packet and its data access
	task automatic run_fp(input int k);
		logic [255:0]     p;
		logic [7:0]       m;
		logic [7:0][31:0] w;
		logic [31:0]      x;
		logic [31:0]      ea;
		logic             uc;
		int               i;
		int               j;
		int               nx [2];
		p = prog_inst.mem[k];
		i = 0;
		j = 0;
		while (ep_valid !== 1'b1 && j < 20) begin
			@(negedge clk);
			j++;
		end
		while (i < 8) begin
			m = '0;
			w = '0;
			uc = 1'b0;
			nx[0] = 0;
			nx[1] = 0;
			do begin
				x = p[32*i +: 32];
				j = int'(x[3:1]);
				if (m[j])
					uc = 1'b1;
				else begin
					m[j] = 1'b1;
					w[j] = x;
				end
				i++;
			end while (x[0] && i < 8);
			for (j = 0; j < 8; j++)
				if (j % 4 != 3 && m[j] && w[j][27] != j[2])
					nx[j / 4]++;
			`CHK(unit_valid, m, "unit_valid")
			for (j = 0; j < 8; j++)
				if (m[j]) `CHK(unit_word[j], w[j], "unit_word")
			`CHK(unit_conflict, uc, "unit_conflict")
			`CHK(ep_valid, 1'b1, "ep_valid")
			`CHK(fetch_req, i == 8, "fetch_req")
			if (i == 8) `CHK(fetch_addr, 32'((k + 1) * 32), "fetch_addr")
			// hold the next answer back until the next scenario has loaded its packet
			if (i == 8)
				lat = 4'hf;
			@(negedge clk);
			// refusal flag is registered, it shows one cycle after its packet
			`CHK(cross_conflict, nx[0] > 1 || nx[1] > 1, "cross_conflict")
			for (j = 0; j < 2; j++) begin
				x = w[4*j+3];
				ea = 32'(x[17:13]) << x[6:5];
				`CHK(dmem_req[j].req, m[4*j+3] && x[31:29] == 3'h0, "dmem_req")
				if (dmem_req[j].req === 1'b1) begin
					`CHK(dmem_req[j].addr, ea, "dmem_addr")
					`CHK(dmem_req[j].we, x[7], "dmem_we")
					`CHK(dmem_req[j].be, x[6:5] == 2'h0 ? 4'h1 << ea[1:0] :
						x[6:5] == 2'h1 ? (ea[1] ? 4'hc : 4'h3) : 4'hf, "dmem_be")
				end
			end
		end
	endtask : run_fp
	// one packet of eight chained words, last chain bit set
	task automatic t_wide();
		`CHK(fetch_req, 1'b1, "fetch_req")
		`CHK(fetch_addr, 32'h0, "fetch_addr")
		for (int i = 0; i < 8; i++)
			prog_inst.mem[0][32*i +: 32] = {28'h0, 3'(i), 1'b1};
		lat = 4'h0;
		run_fp(0);
	endtask : t_wide
	// eight single-word packets, slow memory
	task automatic t_single();
		for (int i = 0; i < 8; i++)
			prog_inst.mem[1][32*i +: 32] = {28'h0, 3'(i), 1'b0};
		lat = 4'h3;
		run_fp(1);
	endtask : t_single
	// mixed lengths with a repeated unit
	task automatic t_dup();
		prog_inst.mem[2] = {32'h7, 32'h9, 32'hd, 32'h5, 32'h2, 32'h3, 32'ha, 32'h1};
		lat = 4'h1;
		run_fp(2);
	endtask : t_dup
	// cross writes, stores of each size, a false condition
	task automatic t_store();
		prog_inst.mem[3] = {32'h0, 32'h0, 32'h0000_20a6, 32'hc000_20a6, 32'h0000_40ce,
			32'h0000_2087, 32'h0800_0002, 32'h0800_0001};
		lat = 4'h2;
		run_fp(3);
	endtask : t_store
	// print counts and verdict, then stop
	task automatic give_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// ****************************************
	// clock, sequence and watchdog
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		reset_n = 1'b0;
		dmem_rdata = '0;
		lat = 4'h0;
		fails = 0;
		compares = 0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		t_wide();
		t_single();
		t_dup();
		t_store();
		give_verdict();
	end
	initial begin
		#40000;
		fails++;
		$display("BAD watchdog exp %h got %h", 1'b0, 1'b1);
		give_verdict();
	end
endmodule : tb
`default_nettype wire
